// ==== core/smc_pkg.sv ====
// Package: constants for the startup mode and comm error timer block
// Assumes a 20 MHz system clock
package smc_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned WAIT_TICK_MS = 100;
  localparam int unsigned WAIT_TICK_CYC = (CLK_HZ / 1000) * WAIT_TICK_MS;
  localparam int unsigned HOUR_S = 3600;
  localparam int unsigned HOUR_TICKS = HOUR_S * 10;
  localparam logic [13:0] WAIT_MAX = 14'h270E;
  localparam logic [13:0] WAIT_RST = 14'h0000;
  localparam logic [15:0] RCT_NONE = 16'h270F;
  localparam logic [15:0] RCT_RST = 16'h270F;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STARTUP = 4'h1;
  localparam logic [3:0] ADR_OPMODE = 4'h2;
  localparam logic [3:0] ADR_WAIT = 4'h3;
  localparam logic [3:0] ADR_COUNT = 4'h4;
  localparam logic [3:0] ADR_RCT = 4'h5;
  localparam logic [3:0] ADR_STATUS = 4'h6;
  localparam logic [3:0] ADR_NVCOUNT = 4'h7;
  localparam int unsigned CTRL_PUKEY = 0;
  localparam int unsigned CTRL_EXTREQ = 1;
  localparam int unsigned CTRL_NETREQ = 2;
  localparam int unsigned CTRL_PUREQ = 3;
  localparam logic [3:0] SU_0 = 4'h0;
  localparam logic [3:0] SU_1 = 4'h1;
  localparam logic [3:0] SU_2 = 4'h2;
  localparam logic [3:0] SU_10 = 4'hA;
  localparam logic [3:0] SU_12 = 4'hC;
  localparam logic [2:0] OP_0 = 3'h0;
  localparam logic [2:0] OP_1 = 3'h1;
  localparam logic [2:0] OP_2 = 3'h2;
  localparam logic [2:0] OP_3 = 3'h3;
  localparam logic [2:0] OP_4 = 3'h4;
  localparam logic [2:0] OP_6 = 3'h6;
  localparam logic [2:0] OP_7 = 3'h7;
  typedef enum logic [3:0] {
    SMC_EXT = 4'b0001,
    SMC_PU = 4'b0010,
    SMC_NET = 4'b0100,
    SMC_EXTPU = 4'b1000
  } smc_mode_e;
endpackage

// ==== core/smc_tick.sv ====
// Tick generator: one-cycle pulse every DIV clocks
// Assumes a free-running clock
`timescale 1ns/100ps
module smc_tick #(
  parameter int unsigned DIV = 2000000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] cnt_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end
    else if (cnt_q >= DIV - 1)
    begin
      cnt_q <= 32'h0;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

// ==== core/smc_errtmr.sv ====
// Comm error qualifier: fault must outlast the wait time to count as an error
// Assumes a 100 ms tick input and a synchronous fault level
`timescale 1ns/100ps
module smc_errtmr (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic fault,
  input wire logic [13:0] wait_ticks,
  output logic err,
  output logic fault_rise
);
  logic fault_q;
  logic [13:0] cnt_q;
  assign fault_rise = fault & ~fault_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      fault_q <= 1'b0;
    else
      fault_q <= fault;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 14'h0;
      err <= 1'b0;
    end
    else if (!fault)
    begin
      cnt_q <= 14'h0; // RULE_20
      err <= 1'b0;
    end
    else if (cnt_q >= wait_ticks)
      err <= 1'b1; // RULE_19
    else if (tick)
      cnt_q <= cnt_q + 14'h1;
  end
endmodule

// ==== core/smc_top.sv ====
// Summary of operation
// RULE_01: Network startup enables parameter writes from the network.
// RULE_02: New startup selection takes effect only at next reset.
// RULE_03: Startup selection writable from panel in any mode.
// RULE_04: Startup 0, opmode 0: external start, switching among all three.
// RULE_05: Opmode 1: panel mode fixed, every switchover refused.
// RULE_06: Startup 0, opmode 2: external start, ext/net only, no panel.
// RULE_07: Opmode 3 or 4: combined ext/panel start, switching refused.
// RULE_08: Startup 0, opmode 6: external start, switching allowed while running.
// RULE_09: Opmode 7: lock off forces external; lock on allows switching.
// RULE_10: Startup 1 or 2: network start for opmode 0,2,6, or 7 locked on.
// RULE_11: Startup 10/12, opmode 0/6: network start, panel/network switching only.
// RULE_12: Startup 10/12, opmode 2: network start, no switching out.
// RULE_13: Startup 10/12, opmode 7: external start, as startup 0.
// RULE_14: Three-mode configurations never jump panel to network directly.
// RULE_15: Restart coast time not 9999: resume previous run state after dip.
// RULE_16: Startup 1 or 10: cancel start command across power failure.
// RULE_17: Panel/network switching by panel key or select input.
// RULE_18: Wait time 0 to 999.8 s in 0.1 s steps, default 0.
// RULE_19: Comm error only when fault outlasts wait time.
// RULE_20: Fault cleared before wait expiry raises no error.
// RULE_21: Error counter increments at each fault start; here it stops at 16'hFFFF and holds that value.
// RULE_22: Writing zero clears counter; only zero accepted; default zero.
// RULE_23: Requester changes mode only when stopped and run inputs off.
// RULE_24: Counter copied to nonvolatile image once per hour.
// RULE_25: Active mode held in state register, loaded at reset.
// Top: operation mode controller and comm error timer, Avalon-MM slave
// Assumes one 20 MHz clock and inputs synchronous to it
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module smc_top
  import smc_pkg::*;
#(
  parameter int unsigned TICK_CYC = smc_pkg::WAIT_TICK_CYC,
  parameter int unsigned HOUR_TK = smc_pkg::HOUR_TICKS
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic AVS_RESPONSE_ERR,
  input wire logic NET_WRITE_REQ,
  input wire logic MODE_LOCK_INPUT,
  input wire logic PANEL_NETWORK_SELECT_INPUT,
  input wire logic FORWARD_RUN_INPUT,
  input wire logic REVERSE_RUN_INPUT,
  input wire logic MOTOR_RUNNING,
  input wire logic POWER_RESTORED,
  input wire logic START_CMD_IN,
  input wire logic COMM_LINE_FAULT,
  output logic [3:0] MODE_OUT,
  output logic NET_PARAM_WRITE_EN,
  output logic START_CMD_OUT,
  output logic RESUME_RUN,
  output logic COMM_ERROR
);
  import smc_pkg::*;

  logic [3:0] startup_sel_q = SU_0;
  logic [3:0] startup_act_q;
  logic [2:0] opmode_sel_q = OP_0;
  logic [13:0] wait_q;
  logic [15:0] count_q;
  logic [15:0] nv_count_q;
  logic [15:0] rct_q;
  logic [3:0] ctrl_pulse;
  logic init_q;
  logic pnsel_q;
  logic start_block_q;
  logic tick;
  logic err;
  logic fault_rise;
  logic [31:0] hour_q;
  smc_mode_e mode_q;
  smc_mode_e mode_d;
  logic busy_q;

  function automatic logic sel_is(input logic [3:0] s, input logic [3:0] a, input logic [3:0] b);
    sel_is = (s == a) || (s == b);
  endfunction

  smc_tick #(
    .DIV(TICK_CYC)
  ) u_tick (
    .clk(CLK),
    .rst(SYS_RST),
    .tick(tick)
  );

  smc_errtmr u_err (
    .clk(CLK),
    .rst(SYS_RST),
    .tick(tick),
    .fault(COMM_LINE_FAULT),
    .wait_ticks(wait_q),
    .err(err),
    .fault_rise(fault_rise)
  );

  wire stopped = ~MOTOR_RUNNING & ~FORWARD_RUN_INPUT & ~REVERSE_RUN_INPUT; // RULE_23
  wire su_net = sel_is(startup_act_q, SU_1, SU_2);
  wire su_pn = sel_is(startup_act_q, SU_10, SU_12);
  wire run_ok = (opmode_sel_q == OP_6) || stopped;
  wire pn_toggle = ctrl_pulse[CTRL_PUKEY] | (PANEL_NETWORK_SELECT_INPUT ^ pnsel_q);

  // Power-on mode from the latched startup and opmode selections
  function automatic smc_mode_e boot_mode(input logic [3:0] su, input logic [2:0] op, input logic lock);
    logic net;
    net = (su != SU_0);
    case (op)
      OP_1: boot_mode = SMC_PU; // RULE_05
      OP_3, OP_4: boot_mode = SMC_EXTPU; // RULE_07
      OP_7: boot_mode = (lock && sel_is(su, SU_1, SU_2)) ? SMC_NET : SMC_EXT; // RULE_09 RULE_13
      OP_0, OP_2, OP_6: boot_mode = net ? SMC_NET : SMC_EXT; // RULE_04 RULE_06 RULE_08 RULE_10 RULE_11 RULE_12
      default: boot_mode = SMC_EXT;
    endcase
  endfunction

  // Switchover decision
  always_comb
  begin
    mode_d = mode_q;
    if (init_q)
      mode_d = boot_mode(startup_sel_q, opmode_sel_q, MODE_LOCK_INPUT); // RULE_25 RULE_02
    else if (opmode_sel_q == OP_7 && !MODE_LOCK_INPUT)
      mode_d = SMC_EXT; // RULE_09
    else if (run_ok)
    begin
      case (opmode_sel_q)
        OP_0, OP_6, OP_7:
        begin
          if (su_pn && opmode_sel_q != OP_7)
          begin
            if (pn_toggle)
              mode_d = (mode_q == SMC_PU) ? SMC_NET : SMC_PU; // RULE_11 RULE_17
          end
          else if (ctrl_pulse[CTRL_EXTREQ])
            mode_d = SMC_EXT;
          else if (ctrl_pulse[CTRL_PUREQ] && mode_q == SMC_EXT)
            mode_d = SMC_PU; // RULE_14
          else if (ctrl_pulse[CTRL_NETREQ] && mode_q == SMC_EXT)
            mode_d = SMC_NET; // RULE_14
        end
        OP_2:
        begin
          if (!su_pn)
          begin
            if (ctrl_pulse[CTRL_EXTREQ])
              mode_d = SMC_EXT; // RULE_06
            else if (ctrl_pulse[CTRL_NETREQ])
              mode_d = SMC_NET;
          end
        end
        default: mode_d = mode_q; // RULE_05 RULE_07 RULE_12
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      init_q <= 1'b1;
      mode_q <= SMC_EXT;
      pnsel_q <= 1'b0;
    end
    else
    begin
      init_q <= 1'b0;
      mode_q <= mode_d;
      pnsel_q <= PANEL_NETWORK_SELECT_INPUT;
    end
  end

  // Startup selection latched only at reset release
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      startup_act_q <= SU_0;
    else if (init_q)
      startup_act_q <= startup_sel_q; // RULE_02
  end

  // Start command gating across power dips
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      start_block_q <= 1'b0;
      START_CMD_OUT <= 1'b0;
      RESUME_RUN <= 1'b0;
    end
    else
    begin
      if (POWER_RESTORED && START_CMD_IN && sel_is(startup_act_q, SU_1, SU_10))
        start_block_q <= 1'b1; // RULE_16
      else if (!START_CMD_IN)
        start_block_q <= 1'b0;
      START_CMD_OUT <= START_CMD_IN & ~start_block_q & ~(POWER_RESTORED & sel_is(startup_act_q, SU_1, SU_10));
      RESUME_RUN <= POWER_RESTORED & (rct_q != RCT_NONE); // RULE_15
    end
  end

  // Error counter and hourly nonvolatile copy
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      count_q <= 16'h0;
      nv_count_q <= 16'h0;
      hour_q <= 32'h0;
    end
    else
    begin
      if (fault_rise && count_q != 16'hFFFF)
        count_q <= count_q + 16'h1; // RULE_21
      else if (busy_q && AVS_WRITE && AVS_ADDRESS == ADR_COUNT && AVS_WRITEDATA == 32'h0)
        count_q <= 16'h0; // RULE_22
      if (tick)
      begin
        if (hour_q >= HOUR_TK - 1)
        begin
          hour_q <= 32'h0;
          nv_count_q <= count_q; // RULE_24
        end
        else
          hour_q <= hour_q + 32'h1;
      end
    end
  end

  // Avalon slave: one wait cycle, answer at second edge
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      busy_q <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
      AVS_RESPONSE_ERR <= 1'b0;
      ctrl_pulse <= 4'h0;
      wait_q <= WAIT_RST;
      rct_q <= RCT_RST;
    end
    else
    begin
      ctrl_pulse <= 4'h0;
      AVS_WAITREQUEST <= 1'b1;
      busy_q <= 1'b0;
      if ((AVS_READ || AVS_WRITE) && !busy_q && AVS_WAITREQUEST)
      begin
        busy_q <= 1'b1;
        AVS_WAITREQUEST <= 1'b0;
        AVS_RESPONSE_ERR <= AVS_ADDRESS > ADR_NVCOUNT;
        case (AVS_ADDRESS)
          ADR_STARTUP: AVS_READDATA <= {28'h0, startup_sel_q};
          ADR_OPMODE: AVS_READDATA <= {29'h0, opmode_sel_q};
          ADR_WAIT: AVS_READDATA <= {18'h0, wait_q};
          ADR_COUNT: AVS_READDATA <= {16'h0, count_q};
          ADR_RCT: AVS_READDATA <= {16'h0, rct_q};
          ADR_STATUS: AVS_READDATA <= {25'h0, NET_PARAM_WRITE_EN, COMM_ERROR, 1'b0, mode_q};
          ADR_NVCOUNT: AVS_READDATA <= {16'h0, nv_count_q};
          default: AVS_READDATA <= 32'h0;
        endcase
      end
      // Writes land at the edge where waitrequest is seen low
      if (busy_q && AVS_WRITE)
      begin
        case (AVS_ADDRESS)
          ADR_CTRL: ctrl_pulse <= AVS_WRITEDATA[3:0];
          ADR_WAIT:
            if (AVS_WRITEDATA[13:0] <= WAIT_MAX && AVS_WRITEDATA[31:14] == 18'h0)
              wait_q <= AVS_WRITEDATA[13:0]; // RULE_18
          ADR_RCT: rct_q <= AVS_WRITEDATA[15:0];
          default: ;
        endcase
      end
    end
  end

  // Selections survive reset; they only start at power-up
  always_ff @(posedge CLK)
  begin
    if (busy_q && AVS_WRITE && AVS_ADDRESS == ADR_STARTUP)
    begin
      if (sel_is(AVS_WRITEDATA[3:0], SU_0, SU_1) || sel_is(AVS_WRITEDATA[3:0], SU_2, SU_10)
          || AVS_WRITEDATA[3:0] == SU_12)
        startup_sel_q <= AVS_WRITEDATA[3:0]; // RULE_03
    end
    if (busy_q && AVS_WRITE && AVS_ADDRESS == ADR_OPMODE)
    begin
      if (AVS_WRITEDATA[2:0] != 3'h5 && stopped)
        opmode_sel_q <= AVS_WRITEDATA[2:0];
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      MODE_OUT <= SMC_EXT;
      NET_PARAM_WRITE_EN <= 1'b0;
      COMM_ERROR <= 1'b0;
    end
    else
    begin
      MODE_OUT <= mode_d;
      NET_PARAM_WRITE_EN <= (mode_d == SMC_NET) & NET_WRITE_REQ; // RULE_01
      COMM_ERROR <= err; // RULE_19
    end
  end
endmodule

// ==== verif/smc_top_monitor.sv ====
// Checker: bus handshake, mode and fault timing at the top ports
// Assumes it is bound to smc_top and sees only its ports
`timescale 1ns/100ps
module smc_top_monitor (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic AVS_RESPONSE_ERR,
  input wire logic NET_WRITE_REQ,
  input wire logic START_CMD_IN,
  input wire logic COMM_LINE_FAULT,
  input wire logic [3:0] MODE_OUT,
  input wire logic NET_PARAM_WRITE_EN,
  input wire logic START_CMD_OUT,
  input wire logic COMM_ERROR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  AST_ONEHOT: assert property ($onehot(MODE_OUT))
    else $error("mode not one-hot");
  AST_NET_WR_ON: assert property ($past(NET_WRITE_REQ) && MODE_OUT == 4'h4 |-> NET_PARAM_WRITE_EN)
    else $error("network write not enabled");
  AST_NET_WR_CAUSE: assert property (NET_PARAM_WRITE_EN |-> $past(NET_WRITE_REQ) && MODE_OUT == 4'h4)
    else $error("network write enabled outside network mode");
  AST_ANSWER: assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST)
    else $error("no answer after one cycle");
  AST_ANSWER_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer longer than one cycle");
  AST_IDLE: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
    else $error("answer without request");
  AST_RESP: assert property (!AVS_WAITREQUEST |-> AVS_RESPONSE_ERR == (AVS_ADDRESS > 4'h7))
    else $error("wrong response code");
  AST_RD_HOLD: assert property (AVS_WAITREQUEST |-> $stable(AVS_READDATA))
    else $error("read data moved between answers");
  AST_ERR_CAUSE: assert property ($rose(COMM_ERROR) |-> $past(COMM_LINE_FAULT))
    else $error("comm error without line fault");
  AST_START: assert property (START_CMD_OUT |-> $past(START_CMD_IN))
    else $error("start output without start input");
endmodule
bind smc_top smc_top_monitor mon (.CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE_ERR(AVS_RESPONSE_ERR),
  .NET_WRITE_REQ(NET_WRITE_REQ), .START_CMD_IN(START_CMD_IN), .COMM_LINE_FAULT(COMM_LINE_FAULT),
  .MODE_OUT(MODE_OUT), .NET_PARAM_WRITE_EN(NET_PARAM_WRITE_EN), .START_CMD_OUT(START_CMD_OUT),
  .COMM_ERROR(COMM_ERROR));

// ==== verif/smc_far_model.sv ====
// Far-side model: network master raising parameter writes and line faults
// Assumes calls are made just after a rising clock edge
`timescale 1ns/100ps
module smc_far_model (
  input wire logic clk,
  output logic net_write_req,
  output logic comm_line_fault
);
  initial
  begin
    net_write_req = 1'b0;
    comm_line_fault = 1'b0;
  end
  // Levels hold until the next call
  task automatic drive(input logic req, input logic fault);
    net_write_req <= req;
    comm_line_fault <= fault;
  endtask
endmodule

// ==== verif/testbench.sv ====
// Testbench: Avalon-MM register tasks, boot and switch tables, fault timing
// Assumes smc_top with shortened tick and hour counts
`timescale 1ns/100ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; $display("MISMATCH %s exp %h seen %h", n, e, s); end end
module testbench;
  logic clk, rst, rd_en, wr_en, lock, sel, fwd, rev, run, pwr, start;
  logic req, fault, waitreq, resp, nwe, sout, resume, cerr;
  logic [3:0] adr;
  logic [3:0] mode;
  logic [31:0] wdata, rdata, r;
  int n_fail = 0;
  int tests_run = 0;
  // Startup, opmode, lock, expected boot mode
  logic [15:0] bt [13] = '{16'h0102, 16'h0201, 16'h0308, 16'h0408, 16'h0601, 16'h0701, 16'h2604,
    16'h1714, 16'h1701, 16'hA004, 16'hC204, 16'hA711, 16'h0001};
  // Startup, opmode, running, control bit, expected mode
  logic [19:0] st [10] = '{20'h00024, 20'h00121, 20'h06124, 20'h01012, 20'h02031, 20'h03028,
    20'h07021, 20'hA0014, 20'hA0002, 20'hC2034};
  smc_top #(.TICK_CYC(4), .HOUR_TK(3)) DUT (.CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .AVS_RESPONSE_ERR(resp), .NET_WRITE_REQ(req), .MODE_LOCK_INPUT(lock),
    .PANEL_NETWORK_SELECT_INPUT(sel), .FORWARD_RUN_INPUT(fwd), .REVERSE_RUN_INPUT(rev),
    .MOTOR_RUNNING(run), .POWER_RESTORED(pwr), .START_CMD_IN(start), .COMM_LINE_FAULT(fault),
    .MODE_OUT(mode), .NET_PARAM_WRITE_EN(nwe), .START_CMD_OUT(sout), .RESUME_RUN(resume),
    .COMM_ERROR(cerr));
  smc_far_model far (.clk(clk), .net_write_req(req), .comm_line_fault(fault));
  task automatic report_and_stop;
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One bus cycle; holds the request until waitrequest is seen low
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr_en <= w;
    rd_en <= !w;
    wdata <= d;
    @(posedge clk);
    #1;
    while (waitreq !== 1'b0)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    r = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask
  // Stores selections, then resets so they take effect
  task automatic cfg(input logic [3:0] su, input logic [2:0] op, input logic lk);
    acc(1'b1, 4'h1, {28'h0, su});
    acc(1'b1, 4'h2, {29'h0, op});
    lock <= lk;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic go(input int b, input logic [3:0] e);
    acc(1'b1, 4'h0, 32'h1 << b);
    repeat (3) @(posedge clk);
    `CHK("mode", e, mode)
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
  initial
  begin
    {rd_en, wr_en, lock, sel, fwd, rev, run, pwr, start} = '0;
    adr = 4'h0;
    wdata = 32'h0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("boot", 4'h1, mode)
    acc(1'b0, 4'h3, 32'h0);
    `CHK("wait", 32'h0, r)
    acc(1'b0, 4'h4, 32'h0);
    `CHK("count", 32'h0, r)
    acc(1'b0, 4'h9, 32'h0);
    acc(1'b1, 4'h1, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("su_hold", 4'h1, mode)
    cfg(4'h1, 3'h0, 1'b0);
    `CHK("su_new", 4'h4, mode)
    foreach (bt[i])
    begin
      cfg(bt[i][15:12], bt[i][10:8], bt[i][4]);
      `CHK("boot", bt[i][3:0], mode)
      acc(1'b0, 4'h1, 32'h0);
      `CHK("su_rd", {28'h0, bt[i][15:12]}, r)
    end
    foreach (st[i])
    begin
      cfg(st[i][19:16], st[i][14:12], 1'b0);
      run <= st[i][8];
      fwd <= st[i][8];
      go(st[i][7:4], st[i][3:0]);
      run <= 1'b0;
      fwd <= 1'b0;
    end
    cfg(4'h0, 3'h0, 1'b0);
    go(2, 4'h4);
    go(3, 4'h4);
    far.drive(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    `CHK("net_wr", 1'b1, nwe)
    cfg(4'hA, 3'h0, 1'b0);
    sel <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("sel_mode", 4'h2, mode)
    `CHK("net_wr_off", 1'b0, nwe)
    far.drive(1'b0, 1'b0);
    cfg(4'h1, 3'h0, 1'b0);
    start <= 1'b1;
    pwr <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("resume_off", 1'b0, resume)
    pwr <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("start_cut", 1'b0, sout)
    start <= 1'b0;
    acc(1'b1, 4'h5, 32'h0);
    pwr <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("resume_on", 1'b1, resume)
    pwr <= 1'b0;
    acc(1'b1, 4'h3, 32'h3);
    far.drive(1'b0, 1'b1);
    repeat (5) @(posedge clk);
    far.drive(1'b0, 1'b0);
    repeat (20) @(posedge clk);
    `CHK("err_short", 1'b0, cerr)
    far.drive(1'b0, 1'b1);
    repeat (40) @(posedge clk);
    `CHK("err_long", 1'b1, cerr)
    far.drive(1'b0, 1'b0);
    acc(1'b0, 4'h4, 32'h0);
    `CHK("count", 32'h2, r)
    repeat (40) @(posedge clk);
    acc(1'b0, 4'h7, 32'h0);
    `CHK("nv_copy", 32'h2, r)
    acc(1'b1, 4'h4, 32'h5);
    acc(1'b0, 4'h4, 32'h0);
    `CHK("count_nz", 32'h2, r)
    acc(1'b1, 4'h4, 32'h0);
    acc(1'b0, 4'h4, 32'h0);
    `CHK("count_clr", 32'h0, r)
    acc(1'b1, 4'h3, 32'h270F);
    acc(1'b0, 4'h3, 32'h0);
    `CHK("wait_over", 32'h3, r)
    report_and_stop;
  end
endmodule
